// ### src/omc_params.svh
`ifndef OMC_PARAMS_SVH
`define OMC_PARAMS_SVH
// Register addresses
`define OMC_ADDR_SCC 3'h0
`define OMC_ADDR_FRC 3'h1
`define OMC_ADDR_FXC 3'h2
`define OMC_ADDR_SXC 3'h3
`define OMC_ADDR_IST 3'h4
`define OMC_ADDR_IMSK 3'h5
`define OMC_ADDR_STAT 3'h6
// System clock control fields
`define OMC_SEL_HI 7
`define OMC_SEL_LO 5
`define OMC_HF_SRC 3
`define OMC_LF_SRC 2
`define OMC_HF_KEEP 1
`define OMC_LF_KEEP 0
`define OMC_SEL_SLOW 3'h7
`define OMC_SCC_RSVD 4
// Oscillator control fields
`define OMC_STABLE 1
`define OMC_EN 0
`define OMC_FREQ_HI 3
`define OMC_FREQ_LO 2
`define OMC_DRIVE 2
`define OMC_FIXED_ONE 2
// Reset values
`define OMC_SCC_RST 8'h00
`define OMC_FRC_EN_RST 1'b1
`define OMC_FREQ_RST 2'h0
// Switch delay in current system clock periods
`define OMC_SWITCH_CNT 3'h4
// Interrupt event bits
`define OMC_EV_HALT 0
`define OMC_EV_WAKE 1
`define OMC_EV_SWITCH 2
`define OMC_EV_FRC 3
`define OMC_EV_FXC 4
`define OMC_EV_SXC 5
`define OMC_EV_W 6
// Synchroniser lanes
`define OMC_SY_FRC 0
`define OMC_SY_FXC 1
`define OMC_SY_SRC 2
`define OMC_SY_SXC 3
`define OMC_SY_FRC_RDY 4
`define OMC_SY_FXC_RDY 5
`define OMC_SY_SXC_RDY 6
`define OMC_SY_W 7
`endif

// ### src/omc_pkg.sv
package omc_pkg;
  // Operating states of the mode controller
  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_IDLE_LOW_ONLY,
    MODE_IDLE_BOTH_CLOCKS,
    MODE_IDLE_HIGH_ONLY,
    MODE_WAKE
  } omc_mode_e;
endpackage : omc_pkg

// ### src/omc_clock_ctrl.sv
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
`include "omc_params.svh"
// Contract
// - Fast mode divides hf_clk by one to 64
// - Select code picks divider or lf_clk
// - Code 111 runs CPU from lf_clk
// - Slow mode hf_clk follows oscillator enable
// - Halt, both keep bits low: sleep
// - Sleep keeps slow RC only with watchdog
// - Halt, low keep only: idle_low_only
// - Halt, both keep bits: idle_both_clocks
// - Halt, high keep only: idle_high_only
// - Bit 3 picks fast RC or crystal
// - Bit 2 picks slow RC or crystal
// - Bit 1 keeps fast oscillator in halt
// - Bit 0 keeps slow oscillator in halt
// - Control bits reset zero, bit 4 zero
// - Clock switch completes after bounded delay
// - Halt sets power-down, clears watchdog state
module omc_clock_ctrl #(
  parameter int DIV_W = 6
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [7:0] o_rd_data,
  input wire logic i_int_fast_rc_clk,
  input wire logic i_ext_fast_xtal_clk,
  input wire logic i_int_slow_rc_clk,
  input wire logic i_ext_slow_xtal_clk,
  input wire logic i_fast_rc_ready,
  input wire logic i_fast_xtal_ready,
  input wire logic i_slow_xtal_ready,
  input wire logic i_halt,
  input wire logic i_wake,
  input wire logic i_wdt_enable,
  input wire logic i_pd_flag_clear,
  output logic o_fast_rc_run,
  output logic o_fast_xtal_run,
  output logic o_slow_rc_run,
  output logic o_slow_xtal_run,
  output logic o_hf_clk_on,
  output logic o_lf_clk_on,
  output logic o_sys_clk_on,
  output logic o_sys_clk_en,
  output logic o_cpu_run,
  output logic o_power_down_flag,
  output logic o_wdt_clear,
  output logic o_irq
);

  // Divider mask: all ones below the chosen power of two
  function automatic logic [DIV_W-1:0] div_mask(input logic [2:0] sel);
    logic [DIV_W:0] one_hot;
    one_hot = '0;
    one_hot[sel] = 1'b1;
    div_mask = DIV_W'(one_hot - 1'b1);
  endfunction : div_mask

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and edge detectors

  logic [`OMC_SY_W-1:0] sync1_reg;
  logic [`OMC_SY_W-1:0] sync2_reg;
  logic [`OMC_SY_W-1:0] sync3_reg;
  logic [`OMC_SY_W-1:0] pin_raw;
  logic [`OMC_SY_W-1:0] pin_rise;

  assign pin_raw = {i_slow_xtal_ready, i_fast_xtal_ready, i_fast_rc_ready,
                    i_ext_slow_xtal_clk, i_int_slow_rc_clk, i_ext_fast_xtal_clk,
                    i_int_fast_rc_clk};
  assign pin_rise = sync2_reg & ~sync3_reg;

  // Oscillators are asynchronous, so two flops before any use
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [7:0] scc_reg, scc_next;
  logic [1:0] frc_freq_reg, frc_freq_next;
  logic frc_en_reg, frc_en_next;
  logic fxc_drive_reg, fxc_drive_next;
  logic fxc_en_reg, fxc_en_next;
  logic sxc_en_reg, sxc_en_next;
  logic [`OMC_EV_W-1:0] imsk_reg, imsk_next;
  logic [7:0] rd_next;
  logic [`OMC_EV_W-1:0] ist_reg, ist_next;
  logic [`OMC_EV_W-1:0] events;
  logic frc_stable_reg, fxc_stable_reg, sxc_stable_reg;
  logic [2:0] act_sel_reg;
  logic act_hf_reg, act_lf_reg;
  logic pending;
  omc_pkg::omc_mode_e mode_reg;

  logic wr_scc, wr_frc, wr_fxc, wr_sxc;
  assign wr_scc = i_wr_en && i_addr == `OMC_ADDR_SCC;
  assign wr_frc = i_wr_en && i_addr == `OMC_ADDR_FRC;
  assign wr_fxc = i_wr_en && i_addr == `OMC_ADDR_FXC;
  assign wr_sxc = i_wr_en && i_addr == `OMC_ADDR_SXC;

  // Writes, read mux and sticky status; a new event beats the read clear
  always_comb begin
    scc_next = scc_reg;
    frc_freq_next = frc_freq_reg;
    frc_en_next = frc_en_reg;
    fxc_drive_next = fxc_drive_reg;
    fxc_en_next = fxc_en_reg;
    sxc_en_next = sxc_en_reg;
    imsk_next = imsk_reg;
    ist_next = ist_reg;
    rd_next = 8'h00;
    if (wr_scc) begin
      scc_next = i_wr_data;
      scc_next[`OMC_SCC_RSVD] = 1'b0;
    end
    if (wr_frc) begin
      frc_freq_next = i_wr_data[`OMC_FREQ_HI:`OMC_FREQ_LO];
      frc_en_next = i_wr_data[`OMC_EN];
    end
    if (wr_fxc) begin
      fxc_drive_next = i_wr_data[`OMC_DRIVE];
      fxc_en_next = i_wr_data[`OMC_EN];
    end
    if (wr_sxc) begin
      sxc_en_next = i_wr_data[`OMC_EN];
    end
    if (i_wr_en && i_addr == `OMC_ADDR_IMSK) begin
      imsk_next = i_wr_data[`OMC_EV_W-1:0];
    end
    if (i_rd_en) begin
      case (i_addr)
        `OMC_ADDR_SCC: rd_next = scc_reg;
        `OMC_ADDR_FRC: rd_next = {4'h0, frc_freq_reg, frc_stable_reg, frc_en_reg};
        `OMC_ADDR_FXC: rd_next = {5'h00, fxc_drive_reg, fxc_stable_reg, fxc_en_reg};
        `OMC_ADDR_SXC: rd_next = {6'h01, sxc_stable_reg, sxc_en_reg};
        `OMC_ADDR_IST: rd_next = {2'h0, ist_reg};
        `OMC_ADDR_IMSK: rd_next = {2'h0, imsk_reg};
        `OMC_ADDR_STAT: rd_next = {3'h0, pending, 1'b0, mode_reg};
        default: rd_next = 8'h00;
      endcase
      if (i_addr == `OMC_ADDR_IST) begin
        ist_next = '0;
      end
    end
    ist_next = ist_next | events;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      scc_reg <= `OMC_SCC_RST;
      frc_freq_reg <= `OMC_FREQ_RST;
      frc_en_reg <= `OMC_FRC_EN_RST;
      fxc_drive_reg <= 1'b0;
      fxc_en_reg <= 1'b0;
      sxc_en_reg <= 1'b0;
      imsk_reg <= '0;
      ist_reg <= '0;
      o_rd_data <= 8'h00;
    end else begin
      scc_reg <= scc_next;
      frc_freq_reg <= frc_freq_next;
      frc_en_reg <= frc_en_next;
      fxc_drive_reg <= fxc_drive_next;
      fxc_en_reg <= fxc_en_next;
      sxc_en_reg <= sxc_en_next;
      imsk_reg <= imsk_next;
      ist_reg <= ist_next;
      o_rd_data <= rd_next;
    end
  end

  assign o_irq = |(ist_reg & imsk_reg);

  //////////////////////////////////////////////////////////////////////////////
  // Oscillator gating per operating mode

  logic hf_on, lf_on, int_slow_rc_on, sys_on;
  logic fast_sel;
  assign fast_sel = act_sel_reg != `OMC_SEL_SLOW;

  always_comb begin
    hf_on = 1'b0;
    lf_on = 1'b0;
    int_slow_rc_on = 1'b1;
    sys_on = 1'b0;
    case (mode_reg)
      omc_pkg::MODE_RUN, omc_pkg::MODE_WAKE: begin
        // Slow mode leaves hf_clk to the chosen oscillator's enable
        hf_on = fast_sel | (act_hf_reg ? fxc_en_reg : frc_en_reg);
        lf_on = 1'b1;
        sys_on = mode_reg == omc_pkg::MODE_RUN;
      end
      omc_pkg::MODE_SLEEP: begin
        int_slow_rc_on = i_wdt_enable;
      end
      omc_pkg::MODE_IDLE_LOW_ONLY: begin
        lf_on = 1'b1;
        sys_on = !fast_sel;
      end
      omc_pkg::MODE_IDLE_BOTH_CLOCKS: begin
        hf_on = 1'b1;
        lf_on = 1'b1;
        sys_on = 1'b1;
      end
      omc_pkg::MODE_IDLE_HIGH_ONLY: begin
        hf_on = 1'b1;
        sys_on = fast_sel;
      end
      default: begin
        hf_on = 1'b0;
      end
    endcase
  end

  // Picked oscillator runs; fast RC and slow crystal also run on their enable bits, slow RC outside sleep
  assign o_fast_rc_run = hf_on & (!act_hf_reg | frc_en_reg);
  assign o_fast_xtal_run = hf_on & act_hf_reg;
  assign o_slow_xtal_run = lf_on & (act_lf_reg | sxc_en_reg);
  assign o_slow_rc_run = int_slow_rc_on | (lf_on & !act_lf_reg);
  assign o_hf_clk_on = hf_on;
  assign o_lf_clk_on = lf_on;
  assign o_sys_clk_on = sys_on;
  assign o_cpu_run = mode_reg == omc_pkg::MODE_RUN;

  //////////////////////////////////////////////////////////////////////////////
  // Clock divider and system clock enable

  logic hf_tick, lf_tick, sys_tick;
  logic [DIV_W-1:0] div_reg, div_next;
  logic [DIV_W-1:0] mask;
  logic adopt;

  assign hf_tick = hf_on & (act_hf_reg ? pin_rise[`OMC_SY_FXC] : pin_rise[`OMC_SY_FRC]);
  assign lf_tick = lf_on & (act_lf_reg ? pin_rise[`OMC_SY_SXC] : pin_rise[`OMC_SY_SRC]);
  assign mask = div_mask(act_sel_reg);
  // One tick per 2^sel fast edges, or every slow edge for code 111
  assign sys_tick = fast_sel ? (hf_tick && (div_reg & mask) == mask) : lf_tick;
  assign o_sys_clk_en = sys_tick & sys_on;

  always_comb begin
    div_next = div_reg;
    if (adopt) begin
      div_next = '0;
    end else if (hf_tick) begin
      div_next = div_reg + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Clock switch: hold the old source for four of its system periods

  logic [2:0] sw_cnt_reg, sw_cnt_next;
  logic [2:0] act_sel_next;
  logic act_hf_next, act_lf_next;

  assign pending = scc_reg[`OMC_SEL_HI:`OMC_SEL_LO] != act_sel_reg
                 || scc_reg[`OMC_HF_SRC] != act_hf_reg
                 || scc_reg[`OMC_LF_SRC] != act_lf_reg;
  assign adopt = pending && sw_cnt_reg == `OMC_SWITCH_CNT;

  always_comb begin
    sw_cnt_next = sw_cnt_reg;
    act_sel_next = act_sel_reg;
    act_hf_next = act_hf_reg;
    act_lf_next = act_lf_reg;
    if (!pending || adopt) begin
      sw_cnt_next = 3'h0;
    end else if (sys_tick) begin
      sw_cnt_next = sw_cnt_reg + 3'h1;
    end
    if (adopt) begin
      act_sel_next = scc_reg[`OMC_SEL_HI:`OMC_SEL_LO];
      act_hf_next = scc_reg[`OMC_HF_SRC];
      act_lf_next = scc_reg[`OMC_LF_SRC];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sw_cnt_reg <= 3'h0;
      act_sel_reg <= 3'h0;
      act_hf_reg <= 1'b0;
      act_lf_reg <= 1'b0;
    end else begin
      sw_cnt_reg <= sw_cnt_next;
      act_sel_reg <= act_sel_next;
      act_hf_reg <= act_hf_next;
      act_lf_reg <= act_lf_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Oscillator stable flags: cleared on (re)start, set by the ready level

  logic frc_stable_next, fxc_stable_next, sxc_stable_next;
  logic frc_restart, fxc_restart, sxc_restart;

  assign frc_restart = wr_frc && ((!frc_en_reg && i_wr_data[`OMC_EN])
                     || frc_freq_reg != i_wr_data[`OMC_FREQ_HI:`OMC_FREQ_LO]);
  assign fxc_restart = wr_fxc && !fxc_en_reg && i_wr_data[`OMC_EN];
  assign sxc_restart = wr_sxc && !sxc_en_reg && i_wr_data[`OMC_EN];

  always_comb begin
    frc_stable_next = o_fast_rc_run & !frc_restart
                    & (frc_stable_reg | sync2_reg[`OMC_SY_FRC_RDY]);
    fxc_stable_next = o_fast_xtal_run & !fxc_restart
                    & (fxc_stable_reg | sync2_reg[`OMC_SY_FXC_RDY]);
    sxc_stable_next = o_slow_xtal_run & !sxc_restart
                    & (sxc_stable_reg | sync2_reg[`OMC_SY_SXC_RDY]);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      frc_stable_reg <= 1'b0;
      fxc_stable_reg <= 1'b0;
      sxc_stable_reg <= 1'b0;
    end else begin
      frc_stable_reg <= frc_stable_next;
      fxc_stable_reg <= fxc_stable_next;
      sxc_stable_reg <= sxc_stable_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Operating mode machine

  omc_pkg::omc_mode_e mode_next;
  logic pd_next, wdt_clr_next;
  logic need_stable;

  // Wake waits for whichever source the current selection needs
  assign need_stable = fast_sel ? (act_hf_reg ? fxc_stable_reg : frc_stable_reg)
                                : (!act_lf_reg | sxc_stable_reg);

  always_comb begin
    mode_next = mode_reg;
    wdt_clr_next = 1'b0;
    pd_next = o_power_down_flag & !i_pd_flag_clear;
    case (mode_reg)
      omc_pkg::MODE_RUN: begin
        if (i_halt) begin
          pd_next = 1'b1;
          wdt_clr_next = 1'b1;
          case ({scc_reg[`OMC_HF_KEEP], scc_reg[`OMC_LF_KEEP]})
            2'h0: mode_next = omc_pkg::MODE_SLEEP;
            2'h1: mode_next = omc_pkg::MODE_IDLE_LOW_ONLY;
            2'h3: mode_next = omc_pkg::MODE_IDLE_BOTH_CLOCKS;
            default: mode_next = omc_pkg::MODE_IDLE_HIGH_ONLY;
          endcase
        end
      end
      omc_pkg::MODE_WAKE: begin
        if (need_stable) begin
          mode_next = omc_pkg::MODE_RUN;
        end
      end
      omc_pkg::MODE_SLEEP, omc_pkg::MODE_IDLE_LOW_ONLY,
      omc_pkg::MODE_IDLE_BOTH_CLOCKS, omc_pkg::MODE_IDLE_HIGH_ONLY: begin
        if (i_wake) begin
          mode_next = omc_pkg::MODE_WAKE;
        end
      end
      default: mode_next = omc_pkg::MODE_RUN;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mode_reg <= omc_pkg::MODE_RUN;
      o_power_down_flag <= 1'b0;
      o_wdt_clear <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      o_power_down_flag <= pd_next;
      o_wdt_clear <= wdt_clr_next;
    end
  end

  // Interrupt events, each a one-cycle pulse
  always_comb begin
    events = '0;
    events[`OMC_EV_HALT] = wdt_clr_next;
    events[`OMC_EV_WAKE] = mode_reg == omc_pkg::MODE_WAKE && need_stable;
    events[`OMC_EV_SWITCH] = adopt;
    events[`OMC_EV_FRC] = frc_stable_next & !frc_stable_reg;
    events[`OMC_EV_FXC] = fxc_stable_next & !fxc_stable_reg;
    events[`OMC_EV_SXC] = sxc_stable_next & !sxc_stable_reg;
  end

endmodule : omc_clock_ctrl

// ### dv/omc_clock_ctrl_asserts.sv
`timescale 1ns/1ps
module omc_clock_ctrl_asserts (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [2:0] i_addr,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] o_rd_data,
  input wire logic i_halt,
  input wire logic i_wdt_enable,
  input wire logic i_pd_flag_clear,
  input wire logic o_fast_rc_run,
  input wire logic o_fast_xtal_run,
  input wire logic o_slow_rc_run,
  input wire logic o_hf_clk_on,
  input wire logic o_lf_clk_on,
  input wire logic o_sys_clk_on,
  input wire logic o_sys_clk_en,
  input wire logic o_cpu_run,
  input wire logic o_power_down_flag,
  input wire logic o_wdt_clear,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Halt entry and its flags
  a_halt_stops_cpu: assert property (i_halt && o_cpu_run |=> !o_cpu_run && o_wdt_clear && o_power_down_flag)
    else $error("halt entry wrong");
  a_wdt_with_halt: assert property ($rose(o_wdt_clear) |-> $fell(o_cpu_run))
    else $error("watchdog clear without halt");
  a_pd_flag_holds: assert property (o_power_down_flag && !i_pd_flag_clear |=> o_power_down_flag)
    else $error("power-down flag lost");
  // Clock gating: in sleep the slow RC follows the watchdog enable, checked once it has been steady five cycles
  a_sleep_wdt_rc: assert property ($stable(i_wdt_enable) [*5] ##0 (!o_cpu_run && !o_hf_clk_on && !o_lf_clk_on && !o_sys_clk_on) |-> o_slow_rc_run == i_wdt_enable)
    else $error("slow rc wrong in sleep");
  a_sys_has_src: assert property (o_sys_clk_on |-> o_hf_clk_on || o_lf_clk_on)
    else $error("system clock without source");
  a_tick_gated: assert property (o_sys_clk_en |-> o_sys_clk_on)
    else $error("tick while system clock off");
  a_fast_src_runs: assert property (o_cpu_run && o_hf_clk_on |-> o_fast_rc_run || o_fast_xtal_run)
    else $error("fast clock on with no oscillator");
  // Register bus and interrupt
  a_bit4_zero: assert property (i_rd_en && i_addr == 3'h0 |=> o_rd_data[4] == 1'b0)
    else $error("control bit 4 not zero");
  a_rd_quiet: assert property (!$past(i_rd_en) |-> o_rd_data == 8'h00)
    else $error("read data outside read slot");
  a_irq_sticky: assert property (o_irq && !(i_rd_en && i_addr == 3'h4) && !(i_wr_en && i_addr == 3'h5) |=> o_irq)
    else $error("interrupt dropped");
endmodule : omc_clock_ctrl_asserts
bind omc_clock_ctrl omc_clock_ctrl_asserts chk_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_addr(i_addr), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
  .i_halt(i_halt), .i_wdt_enable(i_wdt_enable), .i_pd_flag_clear(i_pd_flag_clear),
  .o_fast_rc_run(o_fast_rc_run), .o_fast_xtal_run(o_fast_xtal_run),
  .o_slow_rc_run(o_slow_rc_run), .o_hf_clk_on(o_hf_clk_on), .o_lf_clk_on(o_lf_clk_on),
  .o_sys_clk_on(o_sys_clk_on), .o_sys_clk_en(o_sys_clk_en), .o_cpu_run(o_cpu_run),
  .o_power_down_flag(o_power_down_flag), .o_wdt_clear(o_wdt_clear), .o_irq(o_irq));

// ### dv/omc_clock_ctrl_tb.sv
`timescale 1ns/1ps
module omc_clock_ctrl_tb;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_wr_en = 1'b0, i_rd_en = 1'b0;
  logic [2:0] i_addr = 3'h0, osc_cnt = 3'h0;
  logic [7:0] i_wr_data = 8'h00, o_rd_data, d;
  logic i_halt = 1'b0, i_wake = 1'b0, i_wdt_enable = 1'b0, i_pd_flag_clear = 1'b0;
  logic i_fast_rc_ready = 1'b0, i_fast_xtal_ready = 1'b0, i_slow_xtal_ready = 1'b0;
  logic o_fast_rc_run, o_fast_xtal_run, o_slow_rc_run, o_slow_xtal_run, o_hf_clk_on;
  logic o_lf_clk_on, o_sys_clk_on, o_sys_clk_en, o_cpu_run, o_power_down_flag, o_wdt_clear;
  logic o_irq;
  logic [2:0] mode_of [4] = '{3'h1, 3'h2, 3'h4, 3'h3};
  int mismatches = 0, comparisons = 0;
  // Clock
  always #12.5 i_clk = ~i_clk;
  // Oscillators: fast edge every 4 cycles, slow every 8, slow enough for the synchronisers
  always @(posedge i_clk) osc_cnt <= osc_cnt + 3'h1;
  omc_clock_ctrl dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
    .i_int_fast_rc_clk(osc_cnt[1]), .i_ext_fast_xtal_clk(osc_cnt[1]),
    .i_int_slow_rc_clk(osc_cnt[2]), .i_ext_slow_xtal_clk(osc_cnt[2]),
    .i_fast_rc_ready(i_fast_rc_ready), .i_fast_xtal_ready(i_fast_xtal_ready),
    .i_slow_xtal_ready(i_slow_xtal_ready), .i_halt(i_halt), .i_wake(i_wake),
    .i_wdt_enable(i_wdt_enable), .i_pd_flag_clear(i_pd_flag_clear),
    .o_fast_rc_run(o_fast_rc_run), .o_fast_xtal_run(o_fast_xtal_run),
    .o_slow_rc_run(o_slow_rc_run), .o_slow_xtal_run(o_slow_xtal_run),
    .o_hf_clk_on(o_hf_clk_on), .o_lf_clk_on(o_lf_clk_on), .o_sys_clk_on(o_sys_clk_on),
    .o_sys_clk_en(o_sys_clk_en), .o_cpu_run(o_cpu_run), .o_power_down_flag(o_power_down_flag),
    .o_wdt_clear(o_wdt_clear), .o_irq(o_irq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic hang;
    mismatches++;
    final_report();
  endtask : hang
  // Bus cycles; the trailing delay keeps checks clear of the taking edge
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wr_data <= v;
    i_wr_en <= 1'b1;
    @(posedge i_clk);
    i_wr_en <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_rd_en <= 1'b1;
    @(posedge i_clk);
    i_rd_en <= 1'b0;
    #1 v = o_rd_data;
  endtask : rd
  // Poll pending; per is the old system tick period in clock cycles
  task automatic settle(input int per);
    int n;
    n = 0;
    d = 8'h10;
    while (d[4] === 1'b1 && n < 2000) begin
      rd(3'h6, d);
      n++;
    end
    if (n >= 2000) hang();
    chk("switch_time", 8'(2 * n <= 4 * per + 16), 8'h01);
  endtask : settle
  task automatic ticks(input int e);
    int n;
    n = 0;
    repeat (1024) begin
      @(posedge i_clk);
      #1 n += int'(o_sys_clk_en === 1'b1);
    end
    chk("ticks", 8'(n >= e - 1 && n <= e + 1), 8'h01);
  endtask : ticks
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] exp [5] = '{8'h00, 8'h01, 8'h00, 8'h04, 8'h00};
    for (int a = 0; a < 4; a++) begin
      rd(3'(a), d);
      chk("reset_val", d, exp[a]);
    end
    wr(3'h7, 8'hFF);
    rd(3'h7, d);
    chk("unmapped", d, 8'h00);
    wr(3'h0, 8'h10);
    rd(3'h0, d);
    chk("bit4", d, 8'h00);
  endtask : t_reset
  // Stable flag event, masked then unmasked, cleared by read
  task automatic t_irq;
    @(posedge i_clk);
    i_fast_rc_ready <= 1'b1;
    i_fast_xtal_ready <= 1'b1;
    i_slow_xtal_ready <= 1'b1;
    repeat (12) @(posedge i_clk);
    rd(3'h1, d);
    chk("fast_rc_ctl", d, 8'h03);
    chk("irq_masked", o_irq, 8'h00);
    wr(3'h5, 8'h08);
    chk("irq_on", o_irq, 8'h01);
    rd(3'h4, d);
    chk("status", d, 8'h08);
    chk("irq_off", o_irq, 8'h00);
    // Crystal control fields; the slow crystal runs once enabled, so its flag rises
    wr(3'h2, 8'h05);
    rd(3'h2, d);
    chk("fast_xtal_ctl", d, 8'h05);
    wr(3'h3, 8'h01);
    rd(3'h3, d);
    chk("slow_xtal_ctl", d, 8'h07);
    wr(3'h3, 8'h00);
  endtask : t_irq
  task automatic t_divs;
    int n;
    for (int s = 1; s < 7; s++) begin
      wr(3'h0, {3'(s), 5'h00});
      settle(4 << (s - 1));
      ticks(256 >> s);
    end
    wr(3'h0, 8'hE0);
    settle(256);
    ticks(128);
    chk("slow_lf", o_lf_clk_on, 8'h01);
    chk("slow_hf_en", o_hf_clk_on, 8'h01);
    wr(3'h1, 8'h00);
    chk("slow_hf_dis", o_hf_clk_on, 8'h00);
    chk("slow_rc_off", o_fast_rc_run, 8'h00);
    wr(3'h1, 8'h01);
    // Fast RC restarted: wait for its stable flag before going back to fast
    n = 0;
    d = 8'h00;
    while (d[1] !== 1'b1 && n < 50) begin
      rd(3'h1, d);
      n++;
    end
    if (n >= 50) hang();
    chk("frc_stable", d, 8'h03);
    wr(3'h0, 8'hE4);
    settle(8);
    chk("slow_xtal", o_slow_xtal_run, 8'h01);
    wr(3'h0, 8'h08);
    settle(8);
    chk("fast_xtal", o_fast_xtal_run, 8'h01);
    ticks(256);
    wr(3'h0, 8'h00);
    settle(4);
  endtask : t_divs
  // Every keep-bit pair, from fast and from slow selection
  task automatic t_halt;
    logic slow;
    int n;
    for (int k = 0; k < 8; k++) begin
      slow = k[2];
      i_wdt_enable <= slow;
      wr(3'h0, {slow ? 3'h7 : 3'h0, 3'h0, 2'(k)});
      settle(slow ? 4 : 8);
      @(posedge i_clk);
      i_halt <= 1'b1;
      @(posedge i_clk);
      i_halt <= 1'b0;
      #1;
      chk("cpu", o_cpu_run, 8'h00);
      chk("wdt_clr", o_wdt_clear, 8'h01);
      chk("pd", o_power_down_flag, 8'h01);
      chk("hf_on", o_hf_clk_on, 8'(k[1]));
      chk("lf_on", o_lf_clk_on, 8'(k[0]));
      chk("sys_on", o_sys_clk_on, 8'(k[1:0] == 2'h3 || (k[0] ^ k[1]) && (k[0] == slow)));
      if (k[1:0] == 2'h0) chk("rc_sleep", o_slow_rc_run, 8'(slow));
      rd(3'h6, d);
      chk("mode", d, {5'h00, mode_of[k[1:0]]});
      @(posedge i_clk);
      i_wake <= 1'b1;
      @(posedge i_clk);
      i_wake <= 1'b0;
      n = 0;
      while (o_cpu_run !== 1'b1 && n < 60) begin
        @(posedge i_clk);
        #1 n++;
      end
      if (n >= 60) hang();
      chk("woke", o_sys_clk_on & o_cpu_run, 8'h01);
      @(posedge i_clk);
      i_pd_flag_clear <= 1'b1;
      @(posedge i_clk);
      i_pd_flag_clear <= 1'b0;
      #1 chk("pd_clr", o_power_down_flag, 8'h00);
    end
  endtask : t_halt
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_irq();
    t_divs();
    t_halt();
    final_report();
  end
endmodule : omc_clock_ctrl_tb
